// ### verilog/exec_timing_map.svh
/*
  Constants for the execute-stage occupancy tracker: cycle counts,
  interlock penalty, coprocessor transfer cycles and fetch increments.
  Assumes it is included by bare name from each design file that needs it.
*/
`ifndef EXEC_TIMING_MAP_SVH
`define EXEC_TIMING_MAP_SVH

// Execute occupancy in cycles, per instruction class, no interlock
`define CNT_SINGLE 5'h1
`define CNT_DREAD_BASE 5'h2
`define CNT_SR_READ 5'h2
`define CNT_SR_WRITE_FLAGS 5'h1
`define CNT_SR_WRITE_FULL 5'h3
`define CNT_PROD32 5'h2
`define CNT_PROD32_FLAGS 5'h4
`define CNT_SAT 5'h1
`define CNT_LONG_PROD 5'h3
`define CNT_LONG_PROD_FLAGS 5'h5
`define CNT_HALF_PROD 5'h1
`define CNT_HALF_LONG_ACC 5'h2

// Extra cycle charged to the producer when the consumer needs data early
`define CNT_INTERLOCK 5'h1

// Coprocessor transfer cycles of a double read
`define DREAD_C_CYCLES 5'h2

// Fetch address steps, counted in halfwords (address bits 31:1)
`define FETCH_INC_WORD 31'h2
`define FETCH_INC_HALF 31'h1
`define FETCH_ADDR_RST 31'h0

// First execute cycle index
`define SLOT_IDX_RST 5'h0

`endif

// ### verilog/exec_timing_pkg.sv
/*
  Types shared by the execute-stage occupancy tracker: instruction classes,
  bus cycle types, the decoded instruction and the pipeline slot.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package exec_timing_pkg;

  // Instruction classes whose execute occupancy is tracked
  typedef enum logic [10:0] {
    cls_single = 11'h001,
    cls_dread = 11'h002,
    cls_sr_read = 11'h004,
    cls_sr_write = 11'h008,
    cls_prod32 = 11'h010,
    cls_prod32_flags = 11'h020,
    cls_sat = 11'h040,
    cls_long_prod = 11'h080,
    cls_long_prod_flags = 11'h100,
    cls_half_prod = 11'h200,
    cls_half_long_acc = 11'h400
  } op_class_e;

  // Bus cycle types: nonsequential, sequential, internal, coprocessor
  typedef enum logic [3:0] {
    cyc_n = 4'h1,
    cyc_s = 4'h2,
    cyc_i = 4'h4,
    cyc_c = 4'h8
  } bus_cycle_e;

  // Decoded instruction with what the following instruction needs
  typedef struct packed {
    op_class_e cls;
    logic flags_only;
    logic [3:0] busy_wait;
    logic use_ex1;
    logic use_mem1;
    logic use_acc_only;
    logic use_high_word;
  } instr_s;

  // One pipeline slot (Decode or Execute)
  typedef struct packed {
    logic valid;
    instr_s ins;
    logic [4:0] total;
    logic [4:0] idx;
  } slot_s;

  // Announced bus cycle
  typedef struct packed {
    logic req;
    logic seq;
    bus_cycle_e cyc;
  } bus_s;

endpackage

// ### verilog/occupancy_count.sv
/*
  Execute occupancy of one decoded instruction, interlock included.
  Assumes the decoder fills the dependency flags from the next instruction.
*/
`timescale 1ns/1ps
`include "exec_timing_map.svh"

module occupancy_count (
  input exec_timing_pkg::instr_s ins, // Decoded instruction
  output logic [4:0] total // Execute cycles
);

  wire exec_timing_pkg::op_class_e cls = ins.cls;
  wire early = ins.use_ex1 | ins.use_mem1;
  wire acc_dep = early & ~ins.use_acc_only;
  wire high_dep = acc_dep & ins.use_high_word;
  wire last_dep = early & ins.use_high_word;
  wire [4:0] bw = {1'b0, ins.busy_wait};
  wire [4:0] base;
  wire dep;

  // Base count per class; busy waits stretch the coprocessor read
  assign base =
    (cls == exec_timing_pkg::cls_dread) ? bw + `CNT_DREAD_BASE :
    (cls == exec_timing_pkg::cls_sr_read) ? `CNT_SR_READ :
    (cls == exec_timing_pkg::cls_sr_write) ?
      (ins.flags_only ? `CNT_SR_WRITE_FLAGS : `CNT_SR_WRITE_FULL) :
    (cls == exec_timing_pkg::cls_prod32) ? `CNT_PROD32 :
    (cls == exec_timing_pkg::cls_prod32_flags) ? `CNT_PROD32_FLAGS :
    (cls == exec_timing_pkg::cls_sat) ? `CNT_SAT :
    (cls == exec_timing_pkg::cls_long_prod) ? `CNT_LONG_PROD :
    (cls == exec_timing_pkg::cls_long_prod_flags) ? `CNT_LONG_PROD_FLAGS :
    (cls == exec_timing_pkg::cls_half_prod) ? `CNT_HALF_PROD :
    (cls == exec_timing_pkg::cls_half_long_acc) ? `CNT_HALF_LONG_ACC :
    `CNT_SINGLE;

  // Interlock cost lands on the producer; flag-setting forms never pay it
  assign dep =
    (cls == exec_timing_pkg::cls_prod32) ? acc_dep :
    (cls == exec_timing_pkg::cls_half_prod) ? acc_dep :
    (cls == exec_timing_pkg::cls_long_prod) ? high_dep :
    (cls == exec_timing_pkg::cls_half_long_acc) ? high_dep :
    (cls == exec_timing_pkg::cls_sat) ? ins.use_ex1 :
    (cls == exec_timing_pkg::cls_dread) ? last_dep :
    1'b0;

  assign total = base + (dep ? `CNT_INTERLOCK : 5'h0);

endmodule // occupancy_count

// ### verilog/execute_stage_cycle_timing.sv
/*
  Execute-stage occupancy and bus-cycle announcement for a five-stage
  pipeline. Holds one Decode slot and one Execute slot, stalls Decode while
  a multi-cycle instruction holds Execute, and announces instruction and
  data bus cycles one cycle ahead. Assumes the decoder supplies the class,
  the coprocessor busy count and the dependency flags of the next
  instruction, and that the memory system lowers the clock gate for waits.
  Branches, loads and stores are not tracked here; they count as the plain
  single-cycle class, so their own timing is the decoder's business.
*/
`timescale 1ns/1ps
`include "exec_timing_map.svh"

module execute_stage_cycle_timing (
  input mclk, // Core clock, 200 MHz
  input nrst, // Asynchronous reset, active low
  input core_clock_gate, // Clock enable, low inserts a wait
  input compressed_isa, // High in the 16-bit instruction state
  input issue_valid, // Decoder offers an instruction
  input exec_timing_pkg::instr_s issue, // Offered instruction
  output issue_ready, // Decode slot can take an instruction
  output decode_hold, // Fetch and Decode must not advance
  output ex_busy, // Execute slot occupied
  output [4:0] ex_cycle, // Cycle index within Execute
  output exec_timing_pkg::op_class_e ex_class, // Class in Execute
  output retire, // Last Execute cycle of the instruction
  output exec_timing_pkg::bus_s instr_bus, // Instruction cycle, next cycle
  output exec_timing_pkg::bus_s data_bus, // Data cycle, next cycle
  output [31:1] instr_fetch_address // Address of the announced fetch
);

  // Empty slot, also the reset value of both pipeline slots
  localparam exec_timing_pkg::slot_s idle_slot = '{
    valid: 1'b0,
    ins: '{cls: exec_timing_pkg::cls_single, flags_only: 1'b0, busy_wait: 4'h0,
           use_ex1: 1'b0, use_mem1: 1'b0, use_acc_only: 1'b0, use_high_word: 1'b0},
    total: 5'h0,
    idx: `SLOT_IDX_RST
  };

  // Idle bus: an internal cycle with nothing requested
  localparam exec_timing_pkg::bus_s idle_bus = '{
    req: 1'b0,
    seq: 1'b0,
    cyc: exec_timing_pkg::cyc_i
  };

  // True in the last Execute cycle of a slot
  function automatic logic last_of(input exec_timing_pkg::slot_s s);
    last_of = s.valid && ((s.idx + 5'h1) == s.total);
  endfunction

  // Execute slot one cycle on, given the Decode slot of this cycle
  function automatic exec_timing_pkg::slot_s step(
    input exec_timing_pkg::slot_s cur,
    input exec_timing_pkg::slot_s nxt
  );
    exec_timing_pkg::slot_s r;
    r = nxt;
    if (cur.valid && !last_of(cur))
    begin
      r = cur;
      r.idx = cur.idx + 5'h1;
    end
    step = r;
  endfunction

  // Instruction side: one sequential fetch at entry, internal after
  function automatic exec_timing_pkg::bus_s ibus_of(input exec_timing_pkg::slot_s s);
    exec_timing_pkg::bus_s r;
    r = idle_bus;
    if (s.valid && s.idx == `SLOT_IDX_RST)
    begin
      r = '{req: 1'b1, seq: 1'b1, cyc: exec_timing_pkg::cyc_s};
    end
    ibus_of = r;
  endfunction

  // Data side: C cycles after the busy waits of a double read
  function automatic exec_timing_pkg::bus_s dbus_of(input exec_timing_pkg::slot_s s);
    exec_timing_pkg::bus_s r;
    logic [4:0] lo;
    r = idle_bus;
    lo = {1'b0, s.ins.busy_wait};
    if (s.valid && s.ins.cls == exec_timing_pkg::cls_dread &&
        s.idx >= lo && s.idx < lo + `DREAD_C_CYCLES)
    begin
      r = '{req: 1'b1, seq: 1'b0, cyc: exec_timing_pkg::cyc_c};
    end
    dbus_of = r;
  endfunction

  exec_timing_pkg::slot_s ex_q;
  exec_timing_pkg::slot_s dec_q;
  exec_timing_pkg::bus_s ibus_q;
  exec_timing_pkg::bus_s dbus_q;
  logic ready_q;
  logic hold_q;
  logic retire_q;
  logic [31:1] addr_q;
  logic [4:0] issue_total;

  // Occupancy is fixed when the instruction enters Decode
  occupancy_count u_count (
    .ins(issue),
    .total(issue_total)
  );

  // Decode slot handover: it empties only when Execute takes it
  wire accept = issue_valid && ready_q;
  wire taken = !ex_q.valid || last_of(ex_q);
  wire exec_timing_pkg::slot_s new_slot = '{
    valid: 1'b1,
    ins: issue,
    total: issue_total,
    idx: `SLOT_IDX_RST
  };
  wire exec_timing_pkg::slot_s dec_d =
    accept ? new_slot : (taken ? idle_slot : dec_q);
  wire exec_timing_pkg::slot_s ex_d = step(ex_q, dec_q);

  // Looking two cycles on lets the bus outputs lead Execute by one
  wire exec_timing_pkg::slot_s ex_ahead = step(ex_d, dec_d);
  wire exec_timing_pkg::bus_s ibus_d = ibus_of(ex_ahead);
  wire exec_timing_pkg::bus_s dbus_d = dbus_of(ex_ahead);

  // Ready means the Decode slot is empty or is consumed next cycle
  wire ready_d = !dec_d.valid || !ex_d.valid || last_of(ex_d);
  wire retire_d = last_of(ex_d);

  // Fetch address moves only when a new fetch is announced
  wire [31:1] addr_inc = compressed_isa ? `FETCH_INC_HALF : `FETCH_INC_WORD;
  wire [31:1] addr_d = ibus_d.req ? addr_q + addr_inc : addr_q;

  // Pipeline slots; a low gate freezes everything, stretching time
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      ex_q <= idle_slot;
      dec_q <= idle_slot;
    end
    else if (core_clock_gate)
    begin
      ex_q <= ex_d;
      dec_q <= dec_d;
    end
  end

  // Registered handshake, stall and bus announcements
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      ready_q <= 1'b1;
      hold_q <= 1'b0;
      retire_q <= 1'b0;
      ibus_q <= idle_bus;
      dbus_q <= idle_bus;
      addr_q <= `FETCH_ADDR_RST;
    end
    else if (core_clock_gate)
    begin
      ready_q <= ready_d;
      hold_q <= !ready_d;
      retire_q <= retire_d;
      ibus_q <= ibus_d;
      dbus_q <= dbus_d;
      addr_q <= addr_d;
    end
  end

  // Outputs straight from flip-flops
  assign issue_ready = ready_q;
  assign decode_hold = hold_q;
  assign ex_busy = ex_q.valid;
  assign ex_cycle = ex_q.idx;
  assign ex_class = ex_q.ins.cls;
  assign retire = retire_q;
  assign instr_bus = ibus_q;
  assign data_bus = dbus_q;
  assign instr_fetch_address = addr_q;

  // Helper terms for the checks below; waits are skipped by the gated clock
  wire entry = ex_q.valid && ex_q.idx == `SLOT_IDX_RST;
  wire last_w = last_of(ex_q);
  wire early_w = ex_q.ins.use_ex1 | ex_q.ins.use_mem1;
  wire mdep_w = early_w & ~ex_q.ins.use_acc_only;
  wire hdep_w = mdep_w & ex_q.ins.use_high_word;
  wire ldep_w = early_w & ex_q.ins.use_high_word;
  wire [4:0] bw_w = {1'b0, ex_q.ins.busy_wait};
  wire exec_timing_pkg::op_class_e cls_w = ex_q.ins.cls;

  default clocking cb @(posedge mclk iff core_clock_gate);
  endclocking
  default disable iff (!nrst);

  // Occupancy per class, checked in the entry cycle
  dread_count_a: assert property (entry && cls_w == exec_timing_pkg::cls_dread |->
    ex_q.total == bw_w + (ldep_w ? 5'h3 : 5'h2)) else $error("double read count wrong");
  sr_flags_a: assert property (entry && cls_w == exec_timing_pkg::cls_sr_write &&
    ex_q.ins.flags_only |-> last_w && !data_bus.req) else $error("flag write not one cycle");
  sr_full_a: assert property (entry && cls_w == exec_timing_pkg::cls_sr_write &&
    !ex_q.ins.flags_only |-> !last_w [*2] ##1 last_w) else $error("status write not three");
  prod_count_a: assert property (entry && cls_w == exec_timing_pkg::cls_prod32 |->
    ex_q.total == (mdep_w ? 5'h3 : 5'h2)) else $error("32-bit product count wrong");
  flag_prod_a: assert property (entry && (cls_w == exec_timing_pkg::cls_prod32_flags ||
    cls_w == exec_timing_pkg::cls_long_prod_flags) |->
    ex_q.total == (cls_w == exec_timing_pkg::cls_prod32_flags ? 5'h4 : 5'h5))
    else $error("flag product count wrong");
  sat_count_a: assert property (entry && cls_w == exec_timing_pkg::cls_sat |->
    ex_q.total == (ex_q.ins.use_ex1 ? 5'h2 : 5'h1)) else $error("saturating count wrong");
  long_count_a: assert property (entry && cls_w == exec_timing_pkg::cls_long_prod |->
    ex_q.total == (hdep_w ? 5'h4 : 5'h3)) else $error("long product count wrong");
  half_count_a: assert property (entry && cls_w == exec_timing_pkg::cls_half_prod |->
    ex_q.total == (mdep_w ? 5'h2 : 5'h1)) else $error("halfword product count wrong");
  half_long_a: assert property (entry && cls_w == exec_timing_pkg::cls_half_long_acc |->
    ex_q.total == (hdep_w ? 5'h3 : 5'h2)) else $error("halfword long count wrong");
  sr_read_a: assert property (entry && cls_w == exec_timing_pkg::cls_sr_read |->
    !last_w ##1 last_w) else $error("status read not two cycles");

  // Handover between Decode and Execute; a held slot must not move
  decode_once_a: assert property (dec_q.valid && taken |=> entry &&
    ex_q.ins == $past(dec_q.ins)) else $error("decoded instruction not taken in one cycle");
  exec_hold_a: assert property (ex_q.valid && !last_w |-> decode_hold == dec_q.valid
    ##1 ex_q.idx == $past(ex_q.idx) + 5'h1) else $error("execute left early");
  busy_keep_a: assert property (ex_q.valid && !last_w |=> ex_q.ins == $past(ex_q.ins))
    else $error("held instruction replaced in execute");
  accept_a: assert property (issue_valid && issue_ready |=> dec_q.valid &&
    dec_q.ins == $past(issue)) else $error("accepted instruction not in decode");
  dec_keep_a: assert property (dec_q.valid && !taken |=> dec_q == $past(dec_q))
    else $error("held decode slot overwritten");
  hold_level_a: assert property (decode_hold == !issue_ready)
    else $error("stall and ready disagree");
  idx_bound_a: assert property (ex_q.valid |-> ex_q.idx < ex_q.total)
    else $error("execute index past occupancy");
  single_once_a: assert property (entry && cls_w == exec_timing_pkg::cls_single |->
    last_w) else $error("plain instruction held execute");
  retire_flag_a: assert property (retire == last_w)
    else $error("retire not in last execute cycle");
  retire_next_a: assert property (retire |=> !ex_busy || entry)
    else $error("execute slot reused after retire");
  idle_out_a: assert property (!ex_busy |-> ex_cycle == `SLOT_IDX_RST && !retire &&
    ex_class == exec_timing_pkg::cls_single) else $error("idle execute slot not clean");
  fetch_ahead_a: assert property (instr_bus.req |=> entry)
    else $error("fetch not announced one cycle ahead");
  addr_step_a: assert property (instr_bus.req |-> instr_fetch_address ==
    $past(instr_fetch_address) + ($past(compressed_isa) ? 31'h1 : 31'h2))
    else $error("fetch address step wrong");
  c_cycle_a: assert property (data_bus.cyc == exec_timing_pkg::cyc_c |=>
    cls_w == exec_timing_pkg::cls_dread) else $error("C cycle outside coprocessor read");

  // Bus announcements: one fetch per instruction, C cycles only where due
  entry_fetch_a: assert property (entry |-> $past(instr_bus.req) &&
    $past(instr_bus.cyc) == exec_timing_pkg::cyc_s)
    else $error("entry without an announced fetch");
  intern_only_a: assert property (ex_q.valid && !last_w |-> !instr_bus.req)
    else $error("fetch announced inside a held instruction");
  addr_hold_a: assert property (!instr_bus.req |-> instr_fetch_address ==
    $past(instr_fetch_address)) else $error("fetch address moved without a fetch");
  bus_code_a: assert property (
    instr_bus.req == (instr_bus.cyc == exec_timing_pkg::cyc_s) &&
    data_bus.req == (data_bus.cyc == exec_timing_pkg::cyc_c))
    else $error("bus cycle code wrong");
  dbus_nseq_a: assert property (data_bus.req |-> !data_bus.seq)
    else $error("coprocessor transfer marked sequential");
  dread_slot_a: assert property (ex_q.valid && cls_w == exec_timing_pkg::cls_dread |->
    $past(data_bus.req) == (ex_q.idx >= bw_w && ex_q.idx < bw_w + `DREAD_C_CYCLES))
    else $error("coprocessor transfer cycle misplaced");
  dread_end_a: assert property (last_w && cls_w == exec_timing_pkg::cls_dread |->
    ex_q.idx == bw_w + (ldep_w ? 5'h2 : 5'h1)) else $error("double read ended off count");

  // Gated edges never reach the default clock, so the freeze check uses the raw edge
  freeze_a: assert property (@(posedge mclk) disable iff (!nrst) !core_clock_gate |=>
    $stable(ex_q) && $stable(dec_q) && $stable(ibus_q) && $stable(dbus_q) && $stable(addr_q))
    else $error("state moved while the clock gate was low");

  dread_stall_c: cover property (entry && cls_w == exec_timing_pkg::cls_dread && ldep_w);
  sr_full_c: cover property (entry && cls_w == exec_timing_pkg::cls_sr_write && !last_w);
  long_dep_c: cover property (entry && cls_w == exec_timing_pkg::cls_long_prod && hdep_w);
  back_to_back_c: cover property (last_w ##1 entry ##1 entry);
  wait_stall_c: cover property (@(posedge mclk) disable iff (!nrst) ex_busy && !core_clock_gate);

endmodule // execute_stage_cycle_timing

// ### tb/mem_partner.sv
/*
  Far-side memory model: answers fetches at once, or adds one wait after
  each announced fetch when slow is high, and counts the fetches served.
  Assumes the core announces bus cycles one cycle ahead.
*/
`timescale 1ns/1ps
module mem_partner (
  input wire logic mclk, // Core clock
  input wire logic nrst, // Reset, active low
  input wire logic slow, // Slow memory, adds waits
  input exec_timing_pkg::bus_s instr_bus, // Announced fetch
  output logic core_clock_gate, // Low inserts a wait
  output logic [15:0] fetch_cnt // Fetches served
);
  // A gated edge freezes the core, so a held request is counted only once
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      core_clock_gate <= 1'h1;
      fetch_cnt <= 16'h0;
    end
    else
    begin
      if (core_clock_gate && instr_bus.req)
        fetch_cnt <= fetch_cnt + 16'h1;
      core_clock_gate <= #1 !(slow && instr_bus.req && core_clock_gate);
    end
  end
endmodule // mem_partner

// ### tb/tb.sv
/*
  Self-checking bench for the execute occupancy tracker: random classes,
  notes of expected occupancy in a queue, a negedge monitor that checks them.
  Assumes the memory model in mem_partner drives the clock gate.
*/
`timescale 1ns/1ps
module tb;
  typedef struct {exec_timing_pkg::op_class_e cls; logic [4:0] total; logic [3:0] b;} note_s;
  logic mclk, nrst, compressed_isa, issue_valid, slow, core_clock_gate;
  logic issue_ready, decode_hold, ex_busy, retire, adv, isa_p;
  logic [4:0] ex_cycle;
  logic [31:1] instr_fetch_address, a_p;
  logic [15:0] fetch_cnt;
  logic [31:0] rng;
  exec_timing_pkg::instr_s issue, cur;
  exec_timing_pkg::op_class_e ex_class;
  exec_timing_pkg::bus_s instr_bus, data_bus, ib_p, db_p;
  int num_errors, check_count, issued, busy_n, n;
  note_s q[$];

  // Core clock, 5 ns period
  initial
  begin
    mclk = 1'h0;
    forever #2.5 mclk = ~mclk;
  end

  execute_stage_cycle_timing dut_u (.mclk(mclk), .nrst(nrst),
    .core_clock_gate(core_clock_gate), .compressed_isa(compressed_isa),
    .issue_valid(issue_valid), .issue(issue), .issue_ready(issue_ready),
    .decode_hold(decode_hold), .ex_busy(ex_busy), .ex_cycle(ex_cycle),
    .ex_class(ex_class), .retire(retire), .instr_bus(instr_bus), .data_bus(data_bus),
    .instr_fetch_address(instr_fetch_address));

  mem_partner mem_u (.mclk(mclk), .nrst(nrst), .slow(slow), .instr_bus(instr_bus),
    .core_clock_gate(core_clock_gate), .fetch_cnt(fetch_cnt));

  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction

  // Idle bus unless hit; idle is never a stale copy of a request
  function automatic exec_timing_pkg::bus_s bus_exp(input logic hit, input logic seq,
    input exec_timing_pkg::bus_cycle_e c);
    return hit ? {1'h1, seq, c} : {2'h0, exec_timing_pkg::cyc_i};
  endfunction

  // Execute occupancy expected for one instruction, interlock included
  function automatic logic [4:0] exp_total(input exec_timing_pkg::instr_s i);
    logic e;
    logic x;
    e = i.use_ex1 | i.use_mem1;
    x = e & !i.use_acc_only;
    case (i.cls)
      exec_timing_pkg::cls_dread: return 5'h2 + 5'(i.busy_wait) + 5'(e & i.use_high_word);
      exec_timing_pkg::cls_sr_read: return 5'h2;
      exec_timing_pkg::cls_sr_write: return i.flags_only ? 5'h1 : 5'h3;
      exec_timing_pkg::cls_prod32: return 5'h2 + 5'(x);
      exec_timing_pkg::cls_prod32_flags: return 5'h4;
      exec_timing_pkg::cls_sat: return 5'h1 + 5'(i.use_ex1);
      exec_timing_pkg::cls_long_prod: return 5'h3 + 5'(x & i.use_high_word);
      exec_timing_pkg::cls_long_prod_flags: return 5'h5;
      exec_timing_pkg::cls_half_prod: return 5'h1 + 5'(x);
      exec_timing_pkg::cls_half_long_acc: return 5'h2 + 5'(x & i.use_high_word);
      default: return 5'h1;
    endcase
  endfunction

  task automatic chk(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'h1)
    begin
      num_errors++;
      $display("mismatch t=%0t %s", $time, msg);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Offer until taken; a refused offer is simply held for the next cycle
  task automatic send(input exec_timing_pkg::instr_s ins);
    int k;
    issue = ins;
    issue_valid = 1'h1;
    for (k = 0; k < 64; k++)
    begin
      @(negedge mclk);
      if (issue_ready === 1'h1 && core_clock_gate === 1'h1)
        break;
    end
    if (k == 64)
    begin
      chk(1'h0, "offer timeout");
      wrap_up();
    end
    else
    begin
      q.push_back('{ins.cls, exp_total(ins), ins.busy_wait});
      issued++;
      @(posedge mclk);
      #1;
    end
  endtask

  // Monitor: checks only after an enabled edge, so waits are never counted
  always @(negedge mclk)
  begin
    if (nrst && adv)
    begin
      chk(decode_hold === ~issue_ready, "hold polarity");
      if (ex_busy === 1'h1)
      begin
        busy_n++;
        chk(ex_cycle === 5'(busy_n - 1) && ex_class === q[0].cls, "execute slot");
        chk(db_p === bus_exp(ex_class == exec_timing_pkg::cls_dread &&
          (ex_cycle == 5'(q[0].b) || ex_cycle == 5'(q[0].b) + 5'h1), 1'h0,
          exec_timing_pkg::cyc_c), "coproc cycle");
      end
      chk(ib_p === bus_exp(ex_busy && ex_cycle == 5'h0, 1'h1, exec_timing_pkg::cyc_s),
        "fetch announce");
      chk(instr_fetch_address === a_p + (instr_bus.req ? (isa_p ? 31'h1 : 31'h2) : 31'h0),
        "fetch step");
      if (retire === 1'h1)
      begin
        chk(5'(busy_n) === q[0].total, "occupancy");
        void'(q.pop_front());
        busy_n = 0;
      end
    end
    adv = nrst && core_clock_gate;
    ib_p = instr_bus;
    db_p = data_bus;
    a_p = instr_fetch_address;
    isa_p = compressed_isa;
  end

  // Main sequence: every class first, then random mix with gaps and waits
  initial
  begin
    issue_valid = 1'h0;
    issue = '0;
    compressed_isa = 1'h0;
    slow = 1'h0;
    nrst = 1'h0;
    rng = 32'hcae3;
    num_errors = 0;
    check_count = 0;
    issued = 0;
    busy_n = 0;
    adv = 1'h0;
    repeat (12) @(posedge mclk);
    #1 nrst = 1'h1;
    @(negedge mclk);
    chk({issue_ready, decode_hold, ex_busy, retire, ex_cycle, instr_fetch_address, instr_bus,
      data_bus} === {4'h8, 5'h0, 31'h0, 2'h0, exec_timing_pkg::cyc_i, 2'h0,
      exec_timing_pkg::cyc_i}, "reset state");
    @(posedge mclk);
    #1;
    for (n = 0; n < 400; n++)
    begin
      rng = xs(rng);
      cur = {exec_timing_pkg::op_class_e'(11'h1 << ((n < 11) ? n : rng[7:0] % 11)), rng[16:8]};
      compressed_isa = rng[20];
      slow = rng[21];
      send(cur);
      if (rng[22])
      begin
        issue_valid = 1'h0;
        @(posedge mclk);
        #1;
      end
    end
    issue_valid = 1'h0;
    for (n = 0; n < 300 && q.size() != 0; n++)
      @(posedge mclk);
    chk(q.size() == 0, "drain timeout");
    @(negedge mclk);
    chk(fetch_cnt === 16'(issued), "fetch count");
    wrap_up();
  end
endmodule // tb
